/* design/fpmc_cfg.svh */
/*
   Offsets, field positions, reset values and timing figures for the
   front-panel mode controller. Assumes a 250 MHz hclk and word access.
*/
`ifndef FPMC_CFG_SVH
`define FPMC_CFG_SVH

// Register byte offsets
`define FPMC_REG_STATUS   8'h00
`define FPMC_REG_MEAS     8'h04
`define FPMC_REG_ACQCTR   8'h08
`define FPMC_REG_CENTRE   8'h0c
`define FPMC_REG_OFFSET   8'h10
`define FPMC_REG_DISPLAY  8'h14

// Status field positions
`define FPMC_ST_ENT_LO    8
`define FPMC_ST_MS_LO     10
`define FPMC_ST_RES_LO    12
`define FPMC_ST_ACQ_LO    16
`define FPMC_ST_TB        18

// Reset values and constants
`define FPMC_RES_RST      4'h9
`define FPMC_CHECK_MHZ    32'h0000004b
`define FPMC_CHECK_DIGIT  4'h0

// Timing: clock rate and printed times
`define FPMC_CLK_KHZ      250000
`define FPMC_DEAD_MIN_MS  20
`define FPMC_BLINK_MS     250

`endif

/* design/fpmc_pkg.sv */
/*
   Types for the front-panel mode controller: key codes, states and the
   lamp bundle. Assumes fpmc_cfg.svh for all numeric figures.
*/
`default_nettype none
package fpmc_pkg;

   typedef enum logic [4:0] {
      FPMC_K_D0 = 5'h00, FPMC_K_D1 = 5'h01, FPMC_K_D2 = 5'h02,
      FPMC_K_D3 = 5'h03, FPMC_K_D4 = 5'h04, FPMC_K_D5 = 5'h05,
      FPMC_K_D6 = 5'h06, FPMC_K_D7 = 5'h07, FPMC_K_D8 = 5'h08,
      FPMC_K_D9 = 5'h09, FPMC_K_SHIFT = 5'h0a, FPMC_K_SET = 5'h0b,
      FPMC_K_RESET = 5'h0c, FPMC_K_RECALL = 5'h0d, FPMC_K_CHS = 5'h0e,
      FPMC_K_ENTER = 5'h0f, FPMC_K_AUTO = 5'h10, FPMC_K_MAN = 5'h11,
      FPMC_K_OFS = 5'h12, FPMC_K_LOCK = 5'h13, FPMC_K_SWEEP = 5'h14
   } fpmc_key_t;

   typedef enum logic [1:0] {
      FPMC_ENT_IDLE  = 2'b00,
      FPMC_ENT_SET   = 2'b01,
      FPMC_ENT_ARMED = 2'b11
   } fpmc_ent_t;

   typedef enum logic [1:0] {
      FPMC_MS_DEAD = 2'b00,
      FPMC_MS_TRIG = 2'b01,
      FPMC_MS_GATE = 2'b11
   } fpmc_ms_t;

   typedef struct packed {
      logic auto_lamp;
      logic man_lamp;
      logic ofs_lamp;
      logic sweep_lamp;
      logic lock_lamp;
      logic med_lamp;
      logic slow_lamp;
   } fpmc_lamp_t;

   typedef struct packed {
      logic       key_down;
      logic [4:0] key_code;
      logic       sweep_trig;
      logic       sample_hold;
      logic [7:0] sample_rate;
      logic [1:0] acq_speed;
      logic       tb_source;
   } fpmc_pins_t;

endpackage

`default_nettype wire

/* design/fpmc_top.sv */
/*
   Front-panel key and mode controller with an AHB-Lite register slave,
   measurement sequencer, sweeper handshake and lamp drivers.
   Assumes all panel and sweeper pins are asynchronous to hclk and that
   software supplies measured and acquired frequencies in MHz.
*/
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
// Summary of operation
// - Medium lamp for medium switch position, slow lamp for slow; both dark fast.
// - Key lamp blinks while its function is armed awaiting entry.
// - Key lamp lit steadily while its function is in operation.
// - Power-up selects automatic acquisition mode.
// - After shift, next resolution-row key acts as its blue function.
// - Reset clears display, restarts measurement, clears blinking lamps.
// - Set precedes offset or manual key; dashes shown in GHz digits.
// - Recall then holding manual or offset key shows stored value.
// - Manual centre kept until auto chosen; auto-found centre then replaces.
// - Keyboard lock ignores every key except reset.
// - Sweep key enters sweep mode, flashes lamp, waits for trigger.
// - Lock output asserted for the whole measurement in sweep mode.
// - Lit offset function adds signed stored offset to each reading.
// - Resolution keys pick resolution after shift, else act as digits.
// - Shift then check runs self-check showing 75 MHz; reset exits.
// - Enter ends a digit sequence and stores it.
// - Dead time from 20 ms up to hold; hold freezes the reading.
// - Gate lamp lit exactly while the counting gate is open.
// - Speed switch picks short, medium or long sequence length.
// - Time-base switch picks internal or external 10 MHz reference.
// - Under lock, first reset only releases lock.
// - Reset keeps stored values, steady lamps and operating modes.
// - Own key cancels a steady function; auto and manual exclusive.
`timescale 1ns/1ps
`default_nettype none
`include "fpmc_cfg.svh"

module fpmc_top
   import fpmc_pkg::*;
#(
   parameter int unsigned DEAD_MIN_CYC = `FPMC_DEAD_MIN_MS * `FPMC_CLK_KHZ,
   parameter int unsigned DEAD_STEP_CYC = 1000000,
   parameter int unsigned GATE_CYC = 25000,
   parameter int unsigned BLINK_CYC = `FPMC_BLINK_MS * `FPMC_CLK_KHZ
)
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Panel and sweeper pins
   input  wire fpmc_pins_t  pins,
   // Panel and sweeper outputs
   output fpmc_lamp_t       lamps,
   output logic             gate_lamp,
   output logic             set_dashes,
   output logic [31:0]      display,
   output logic             sweep_lock,
   output logic [1:0]       prs_length,
   output logic             tb_select,
   output logic [3:0]       resolution
);

   function automatic logic is_digit(input logic [4:0] c);
      is_digit = (c <= 5'h09);
   endfunction

   // Two-stage synchroniser
   fpmc_pins_t s1_ff;
   fpmc_pins_t s2_ff;
   logic       kd_prev_ff;
   logic       trig_prev_ff;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_ff        <= '0;
         s2_ff        <= '0;
         kd_prev_ff   <= 1'b0;
         trig_prev_ff <= 1'b0;
      end
      else
      begin
         s1_ff        <= pins;
         s2_ff        <= s1_ff;
         kd_prev_ff   <= s2_ff.key_down;
         trig_prev_ff <= s2_ff.sweep_trig;
      end
   end

   logic      press;
   fpmc_key_t code;
   logic      trig_rise;
   assign press     = s2_ff.key_down & ~kd_prev_ff;
   assign code      = fpmc_key_t'(s2_ff.key_code);
   assign trig_rise = s2_ff.sweep_trig & ~trig_prev_ff;

   // Bus slave: zero wait states, always OKAY
   logic [7:0]  addr_ff;
   logic        wr_ff;
   logic [31:0] rdata_ff;
   logic [31:0] meas_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] nxt_meas;
   logic        acq_wr;
   logic [31:0] status;
   logic [31:0] centre_ff;
   logic [31:0] offset_ff;
   logic [31:0] disp_ff;

   always_comb
   begin
      nxt_rdata = rdata_ff;
      nxt_meas  = meas_ff;
      acq_wr    = wr_ff & (addr_ff == `FPMC_REG_ACQCTR);
      if (wr_ff && addr_ff == `FPMC_REG_MEAS)
         nxt_meas = hwdata;
      if (hsel && htrans[1] && hready && !hwrite)
      begin
         case (haddr)
            `FPMC_REG_STATUS:  nxt_rdata = status;
            `FPMC_REG_MEAS:    nxt_rdata = meas_ff;
            `FPMC_REG_CENTRE:  nxt_rdata = centre_ff;
            `FPMC_REG_OFFSET:  nxt_rdata = offset_ff;
            `FPMC_REG_DISPLAY: nxt_rdata = disp_ff;
            default:           nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_ff   <= 8'h00;
         wr_ff     <= 1'b0;
         rdata_ff  <= 32'h00000000;
         meas_ff   <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         addr_ff   <= haddr;
         wr_ff     <= hsel & htrans[1] & hready & hwrite;
         rdata_ff  <= nxt_rdata;
         meas_ff   <= nxt_meas;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   assign hrdata = rdata_ff;

   // Key interpreter and operating modes
   fpmc_ent_t   ent_ff, nxt_ent;
   logic        tgt_ofs_ff, nxt_tgt_ofs;
   logic [23:0] pend_ff, nxt_pend;
   logic        pneg_ff, nxt_pneg;
   logic        auto_ff, nxt_auto;
   logic        man_ff, nxt_man;
   logic        ofs_ff, nxt_ofs;
   logic        sweep_ff, nxt_sweep;
   logic        lock_ff, nxt_lock;
   logic        check_ff, nxt_check;
   logic        shift_ff, nxt_shift;
   logic        recall_ff, nxt_recall;
   logic [3:0]  res_ff, nxt_res;
   logic [31:0] nxt_centre, nxt_offset;
   logic        restart;
   logic [31:0] pend_signed;

   assign pend_signed = pneg_ff ? (32'h00000000 - {8'h00, pend_ff})
                                : {8'h00, pend_ff};

   always_comb
   begin
      nxt_ent     = ent_ff;
      nxt_tgt_ofs = tgt_ofs_ff;
      nxt_pend    = pend_ff;
      nxt_pneg    = pneg_ff;
      nxt_auto    = auto_ff;
      nxt_man     = man_ff;
      nxt_ofs     = ofs_ff;
      nxt_sweep   = sweep_ff;
      nxt_lock    = lock_ff;
      nxt_check   = check_ff;
      nxt_shift   = shift_ff;
      nxt_recall  = recall_ff;
      nxt_res     = res_ff;
      nxt_centre  = centre_ff;
      nxt_offset  = offset_ff;
      restart     = 1'b0;
      if (acq_wr && auto_ff)
         nxt_centre = hwdata;
      if (press && lock_ff)
      begin
         if (code == FPMC_K_RESET)
            nxt_lock = 1'b0;
      end
      else if (press)
      begin
         nxt_shift  = 1'b0;
         nxt_recall = 1'b0;
         case (code)
            FPMC_K_RESET:
            begin
               // Stored values and steady modes survive
               nxt_ent   = FPMC_ENT_IDLE;
               nxt_check = 1'b0;
               nxt_pend  = 24'h000000;
               nxt_pneg  = 1'b0;
               restart   = 1'b1;
            end
            FPMC_K_SHIFT:  nxt_shift = 1'b1;
            FPMC_K_SET:    nxt_ent = FPMC_ENT_SET;
            FPMC_K_RECALL: nxt_recall = 1'b1;
            FPMC_K_LOCK:   nxt_lock = 1'b1;
            FPMC_K_SWEEP:  nxt_sweep = ~sweep_ff;
            FPMC_K_CHS:
               if (ent_ff == FPMC_ENT_ARMED)
                  nxt_pneg = ~pneg_ff;
            FPMC_K_AUTO:
            begin
               nxt_auto = 1'b1;
               nxt_man  = 1'b0;
            end
            FPMC_K_MAN, FPMC_K_OFS:
            begin
               if (recall_ff)
                  nxt_recall = 1'b1;
               else if (ent_ff == FPMC_ENT_SET)
               begin
                  nxt_ent     = FPMC_ENT_ARMED;
                  nxt_tgt_ofs = (code == FPMC_K_OFS);
                  nxt_pend    = 24'h000000;
                  nxt_pneg    = 1'b0;
               end
               else if (code == FPMC_K_OFS)
                  nxt_ofs = ~ofs_ff;
               else if (man_ff)
               begin
                  nxt_man  = 1'b0;
                  nxt_auto = 1'b1;
               end
            end
            FPMC_K_ENTER:
               if (ent_ff == FPMC_ENT_ARMED)
               begin
                  nxt_ent = FPMC_ENT_IDLE;
                  if (tgt_ofs_ff)
                  begin
                     nxt_offset = pend_signed;
                     nxt_ofs    = 1'b1;
                  end
                  else
                  begin
                     nxt_centre = {8'h00, pend_ff};
                     nxt_man    = 1'b1;
                     nxt_auto   = 1'b0;
                  end
               end
            default:
               if (is_digit(code))
               begin
                  if (shift_ff)
                  begin
                     if (code[3:0] == `FPMC_CHECK_DIGIT)
                        nxt_check = 1'b1;
                     else
                        nxt_res = code[3:0];
                  end
                  else if (ent_ff == FPMC_ENT_ARMED)
                     nxt_pend = 24'(pend_ff * 24'd10) + {20'h00000, code[3:0]};
               end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ent_ff     <= FPMC_ENT_IDLE;
         tgt_ofs_ff <= 1'b0;
         pend_ff    <= 24'h000000;
         pneg_ff    <= 1'b0;
         auto_ff    <= 1'b1;
         man_ff     <= 1'b0;
         ofs_ff     <= 1'b0;
         sweep_ff   <= 1'b0;
         lock_ff    <= 1'b0;
         check_ff   <= 1'b0;
         shift_ff   <= 1'b0;
         recall_ff  <= 1'b0;
         res_ff     <= `FPMC_RES_RST;
         centre_ff  <= 32'h00000000;
         offset_ff  <= 32'h00000000;
      end
      else
      begin
         ent_ff     <= nxt_ent;
         tgt_ofs_ff <= nxt_tgt_ofs;
         pend_ff    <= nxt_pend;
         pneg_ff    <= nxt_pneg;
         auto_ff    <= nxt_auto;
         man_ff     <= nxt_man;
         ofs_ff     <= nxt_ofs;
         sweep_ff   <= nxt_sweep;
         lock_ff    <= nxt_lock;
         check_ff   <= nxt_check;
         shift_ff   <= nxt_shift;
         recall_ff  <= nxt_recall;
         res_ff     <= nxt_res;
         centre_ff  <= nxt_centre;
         offset_ff  <= nxt_offset;
      end
   end

   // Measurement sequencer
   fpmc_ms_t    ms_ff, nxt_ms;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [31:0] dead_cyc;
   logic        meas_done;
   assign dead_cyc = DEAD_MIN_CYC
                   + 32'(s2_ff.sample_rate) * DEAD_STEP_CYC;

   always_comb
   begin
      nxt_ms    = ms_ff;
      nxt_cnt   = cnt_ff + 32'h00000001;
      meas_done = 1'b0;
      case (ms_ff)
         FPMC_MS_DEAD:
            if (s2_ff.sample_hold)
               nxt_cnt = cnt_ff;
            else if (cnt_ff >= dead_cyc - 32'h00000001)
            begin
               nxt_ms  = sweep_ff ? FPMC_MS_TRIG : FPMC_MS_GATE;
               nxt_cnt = 32'h00000000;
            end
         FPMC_MS_TRIG:
         begin
            nxt_cnt = 32'h00000000;
            if (!sweep_ff || trig_rise)
               nxt_ms = FPMC_MS_GATE;
         end
         FPMC_MS_GATE:
            if (cnt_ff >= GATE_CYC - 1)
            begin
               nxt_ms    = FPMC_MS_DEAD;
               nxt_cnt   = 32'h00000000;
               meas_done = 1'b1;
            end
         default:
         begin
            nxt_ms  = FPMC_MS_DEAD;
            nxt_cnt = 32'h00000000;
         end
      endcase
      if (restart)
      begin
         nxt_ms  = sweep_ff ? FPMC_MS_TRIG : FPMC_MS_GATE;
         nxt_cnt = 32'h00000000;
      end
   end

   // Display, lamps and blink timing
   logic [31:0] blink_cnt_ff, nxt_blink_cnt;
   logic        blink_ff, nxt_blink;
   logic [31:0] nxt_disp;
   logic        held_man, held_ofs;
   fpmc_lamp_t  nxt_lamps;
   assign held_man = recall_ff & s2_ff.key_down & (code == FPMC_K_MAN);
   assign held_ofs = recall_ff & s2_ff.key_down & (code == FPMC_K_OFS);

   always_comb
   begin
      nxt_blink_cnt = blink_cnt_ff + 32'h00000001;
      nxt_blink     = blink_ff;
      if (blink_cnt_ff >= BLINK_CYC - 1)
      begin
         nxt_blink_cnt = 32'h00000000;
         nxt_blink     = ~blink_ff;
      end
      nxt_disp = disp_ff;
      // Reset wins so that leaving self-check clears the display
      if (restart)
         nxt_disp = 32'h00000000;
      else if (check_ff)
         nxt_disp = `FPMC_CHECK_MHZ;
      else if (held_man)
         nxt_disp = centre_ff;
      else if (held_ofs)
         nxt_disp = offset_ff;
      else if (meas_done)
         nxt_disp = ofs_ff ? meas_ff + offset_ff : meas_ff;
      nxt_lamps.auto_lamp  = auto_ff;
      nxt_lamps.man_lamp   = (ent_ff == FPMC_ENT_ARMED && !tgt_ofs_ff)
                           ? blink_ff : man_ff;
      nxt_lamps.ofs_lamp   = (ent_ff == FPMC_ENT_ARMED && tgt_ofs_ff)
                           ? blink_ff : ofs_ff;
      nxt_lamps.sweep_lamp = sweep_ff & ((ms_ff == FPMC_MS_TRIG)
                           ? blink_ff : 1'b1);
      nxt_lamps.lock_lamp  = lock_ff;
      nxt_lamps.med_lamp   = (s2_ff.acq_speed == 2'b01);
      nxt_lamps.slow_lamp  = (s2_ff.acq_speed == 2'b10);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ms_ff        <= FPMC_MS_DEAD;
         cnt_ff       <= 32'h00000000;
         blink_cnt_ff <= 32'h00000000;
         blink_ff     <= 1'b0;
         disp_ff      <= 32'h00000000;
         lamps        <= '0;
         gate_lamp    <= 1'b0;
         sweep_lock   <= 1'b0;
         set_dashes   <= 1'b0;
         prs_length   <= 2'b00;
         tb_select    <= 1'b0;
      end
      else
      begin
         ms_ff        <= nxt_ms;
         cnt_ff       <= nxt_cnt;
         blink_cnt_ff <= nxt_blink_cnt;
         blink_ff     <= nxt_blink;
         disp_ff      <= nxt_disp;
         lamps        <= nxt_lamps;
         gate_lamp    <= (nxt_ms == FPMC_MS_GATE);
         sweep_lock   <= (nxt_ms == FPMC_MS_GATE) & nxt_sweep;
         set_dashes   <= (nxt_ent == FPMC_ENT_SET);
         prs_length   <= s2_ff.acq_speed;
         tb_select    <= s2_ff.tb_source;
      end
   end

   assign display    = disp_ff;
   assign resolution = res_ff;
   assign status = {13'h0000, s2_ff.tb_source, s2_ff.acq_speed, res_ff,
                    ms_ff, ent_ff, recall_ff, shift_ff, check_ff,
                    lock_ff, sweep_ff, ofs_ff, man_ff, auto_ff};

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_lock_ignores: assert property (lock_ff && press && code != FPMC_K_RESET
      |=> $stable(auto_ff) && $stable(ofs_ff) && $stable(ent_ff))
      else $error("key acted under lock");
   a_lock_release: assert property (lock_ff && press && code == FPMC_K_RESET
      |=> !lock_ff && $stable(ent_ff) && $stable(check_ff))
      else $error("first reset under lock did more than unlock");
   a_reset_blink: assert property (!lock_ff && press && code == FPMC_K_RESET
      |=> ent_ff == FPMC_ENT_IDLE && !check_ff ##1 disp_ff == 0)
      else $error("reset left entry, check or display");
   a_reset_keeps: assert property (!lock_ff && press && code == FPMC_K_RESET
      && !acq_wr |=> $stable(offset_ff) && $stable(centre_ff)
      && $stable(man_ff) && $stable(ofs_ff))
      else $error("reset lost stored state");
   a_gate_lamp: assert property (gate_lamp == (ms_ff == FPMC_MS_GATE))
      else $error("gate lamp out of step with gate");
   a_sweep_lock: assert property (sweep_lock |-> gate_lamp && sweep_ff)
      else $error("sweeper lock outside sweep measurement");
   a_speed_lamps: assert property (lamps.med_lamp
      == ($past(s2_ff.acq_speed) == 2'b01) && !(lamps.med_lamp
      && lamps.slow_lamp))
      else $error("speed lamps wrong");
   a_check_disp: assert property (check_ff && !restart
      |=> disp_ff == 32'h0000004b)
      else $error("self-check display not 75");
   a_enter_store: assert property (!lock_ff && press
      && code == FPMC_K_ENTER && ent_ff == FPMC_ENT_ARMED && tgt_ofs_ff
      |=> offset_ff == $past(pend_signed) && ofs_ff)
      else $error("entered offset not stored");
   a_pending_only: assert property (ent_ff == FPMC_ENT_ARMED && press
      && is_digit(code) |=> $stable(offset_ff))
      else $error("digit changed stored offset");
   a_mode_excl: assert property (!(auto_ff && man_ff))
      else $error("auto and manual both active");

   c_offset_entry: cover property (press && code == FPMC_K_ENTER
      && ent_ff == FPMC_ENT_ARMED && tgt_ofs_ff);
   c_sweep_trig: cover property (ms_ff == FPMC_MS_TRIG && trig_rise);
   c_self_check: cover property (check_ff ##1 disp_ff == 32'h0000004b);
   c_hold: cover property ((ms_ff == FPMC_MS_DEAD && s2_ff.sample_hold) [*4]);

endmodule // fpmc_top

`default_nettype wire

/* tb/fpmc_panel_model.sv */
/*
   Operator keyboard and sweep generator model for fpmc_top.
   Assumes the bench calls press and trig from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module fpmc_panel_model
   import fpmc_pkg::*;
(
   // Clock
   input  wire logic       hclk,
   // Rear-panel settings
   input  wire logic [1:0] acq_speed,
   input  wire logic       tb_source,
   input  wire logic       sample_hold,
   input  wire logic [7:0] sample_rate,
   // Panel and sweeper pins
   output var fpmc_pins_t  pins
);
   logic       key_down_ff = 1'b0;
   logic [4:0] key_code_ff = 5'h1f;
   logic       trig_ff     = 1'b0;

   assign pins = {key_down_ff, key_code_ff, trig_ff, sample_hold,
                  sample_rate, acq_speed, tb_source};

   // Released code lines show the inverse, so a stale code cannot pass
   task press(input logic [4:0] c, input int hold);
      @(posedge hclk);
      key_down_ff <= 1'b1;
      key_code_ff <= c;
      repeat (hold) @(posedge hclk);
      key_down_ff <= 1'b0;
      key_code_ff <= ~c;
      repeat (6) @(posedge hclk);
   endtask

   task trig();
      @(posedge hclk);
      trig_ff <= 1'b1;
      repeat (4) @(posedge hclk);
      trig_ff <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
endmodule // fpmc_panel_model
`default_nettype wire

/* tb/counter_front_panel_mode_control_tb_top.sv */
/*
   Self-checking bench for fpmc_top: panel table loop, then key scenarios.
   Assumes fpmc_panel_model drives the pins and this bench masters AHB.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpmc_cfg.svh"

module counter_front_panel_mode_control_tb_top;
   import fpmc_pkg::*;
   logic        hclk;
   logic        hresetn, hsel, hwrite, hreadyout, hresp, gate_lamp;
   logic        set_dashes, sweep_lock, tb_select, tb_source, sample_hold;
   logic        toggled;
   logic [7:0]  haddr, sample_rate;
   logic [1:0]  htrans, prs_length, acq_speed;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, display, rdv;
   logic [3:0]  resolution;
   logic [6:0]  rows [3];
   fpmc_pins_t  pins;
   fpmc_lamp_t  lamps;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          hi;

   fpmc_top #(.DEAD_MIN_CYC(20), .DEAD_STEP_CYC(4), .GATE_CYC(8),
      .BLINK_CYC(4)) fpmc_top_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
      .lamps(lamps), .gate_lamp(gate_lamp), .set_dashes(set_dashes),
      .display(display), .sweep_lock(sweep_lock), .prs_length(prs_length),
      .tb_select(tb_select), .resolution(resolution));

   fpmc_panel_model fpmc_panel_model_inst (.hclk(hclk),
      .acq_speed(acq_speed), .tb_source(tb_source),
      .sample_hold(sample_hold), .sample_rate(sample_rate), .pins(pins));

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task test_done();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard well above the several hundred cycles the run needs
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         bad_count++;
         test_done();
      end
   end

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdv = hrdata;
      chk(32'({hreadyout, hresp}), 32'h2);
   endtask

   task key(input logic [4:0] c);
      fpmc_panel_model_inst.press(c, 4);
   endtask

   task wait_gate(input logic v);
      for (int i = 0; i < 300 && gate_lamp !== v; i++) @(posedge hclk);
   endtask

   task watch_ofs();
      logic v;
      v = lamps.ofs_lamp;
      toggled = 1'b0;
      repeat (12)
      begin
         @(posedge hclk);
         if (lamps.ofs_lamp !== v) toggled = 1'b1;
      end
   endtask

   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'b010;
      {acq_speed, tb_source, sample_hold, sample_rate} = '0;
      hresetn = 1'b0;
      // Rows: speed, source, expected length, medium lamp, slow lamp
      rows = '{7'b00_0_00_00, 7'b01_1_01_10, 7'b10_0_10_01};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(32'(resolution), 32'h9);
      chk(32'(lamps.auto_lamp), 32'h1);
      foreach (rows[i])
      begin
         acq_speed <= rows[i][6:5];
         tb_source <= rows[i][4];
         repeat (5) @(posedge hclk);
         chk(32'(prs_length), 32'(rows[i][3:2]));
         chk(32'({lamps.med_lamp, lamps.slow_lamp}), 32'(rows[i][1:0]));
         chk(32'(tb_select), 32'(rows[i][4]));
      end
      xfer(1'b0, 8'h20, 32'h0);
      chk(rdv, 32'h0);
      key(FPMC_K_SET);
      chk(32'(set_dashes), 32'h1);
      key(FPMC_K_OFS);
      watch_ofs();
      chk(32'(toggled), 32'h1);
      key(FPMC_K_D1);
      key(FPMC_K_D2);
      xfer(1'b0, `FPMC_REG_OFFSET, 32'h0);
      chk(rdv, 32'h0);
      key(FPMC_K_CHS);
      key(FPMC_K_ENTER);
      xfer(1'b0, `FPMC_REG_OFFSET, 32'h0);
      chk(rdv, 32'hfffffff4);
      watch_ofs();
      chk(32'({toggled, lamps.ofs_lamp}), 32'h1);
      xfer(1'b1, `FPMC_REG_MEAS, 32'h3e8);
      wait_gate(1'b1);
      wait_gate(1'b0);
      wait_gate(1'b1);
      chk(32'(gate_lamp), 32'h1);
      wait_gate(1'b0);
      repeat (2) @(posedge hclk);
      chk(display, 32'h3dc);
      key(FPMC_K_RECALL);
      fork
         fpmc_panel_model_inst.press(FPMC_K_OFS, 14);
         begin
            repeat (10) @(posedge hclk);
            chk(display, 32'hfffffff4);
         end
      join
      key(FPMC_K_SHIFT);
      key(FPMC_K_D3);
      chk(32'(resolution), 32'h3);
      key(FPMC_K_SHIFT);
      key(FPMC_K_D0);
      wait_gate(1'b1);
      wait_gate(1'b0);
      repeat (2) @(posedge hclk);
      chk(display, `FPMC_CHECK_MHZ);
      key(FPMC_K_RESET);
      xfer(1'b0, `FPMC_REG_STATUS, 32'h0);
      chk(32'(rdv[5]), 32'h0);
      key(FPMC_K_SET);
      key(FPMC_K_MAN);
      key(FPMC_K_D5);
      key(FPMC_K_D0);
      key(FPMC_K_ENTER);
      chk(32'({lamps.auto_lamp, lamps.man_lamp}), 32'h1);
      xfer(1'b1, `FPMC_REG_ACQCTR, 32'h4d);
      xfer(1'b0, `FPMC_REG_CENTRE, 32'h0);
      chk(rdv, 32'h32);
      key(FPMC_K_AUTO);
      chk(32'({lamps.auto_lamp, lamps.man_lamp}), 32'h2);
      xfer(1'b1, `FPMC_REG_ACQCTR, 32'h4d);
      xfer(1'b0, `FPMC_REG_CENTRE, 32'h0);
      chk(rdv, 32'h4d);
      key(FPMC_K_RECALL);
      fork
         fpmc_panel_model_inst.press(FPMC_K_MAN, 14);
         begin
            repeat (10) @(posedge hclk);
            chk(display, 32'h4d);
         end
      join
      key(FPMC_K_LOCK);
      key(FPMC_K_SET);
      chk(32'({set_dashes, lamps.lock_lamp}), 32'h1);
      key(FPMC_K_RESET);
      xfer(1'b0, `FPMC_REG_STATUS, 32'h0);
      chk(32'(rdv[4]), 32'h0);
      key(FPMC_K_SET);
      key(FPMC_K_RESET);
      chk(32'({set_dashes, lamps.ofs_lamp}), 32'h1);
      xfer(1'b0, `FPMC_REG_OFFSET, 32'h0);
      chk(rdv, 32'hfffffff4);
      // Hold freezes dead time, so no gate may open
      sample_hold <= 1'b1;
      wait_gate(1'b0);
      hi = 0;
      repeat (100)
      begin
         @(posedge hclk);
         hi += int'(gate_lamp === 1'b1);
      end
      chk(32'(hi), 32'h0);
      sample_hold <= 1'b0;
      key(FPMC_K_SWEEP);
      repeat (60) @(posedge hclk);
      xfer(1'b0, `FPMC_REG_STATUS, 32'h0);
      chk(32'({rdv[11:10], gate_lamp}), 32'h2);
      fpmc_panel_model_inst.trig();
      wait_gate(1'b1);
      chk(32'({gate_lamp, sweep_lock, lamps.sweep_lamp}), 32'h7);
      test_done();
   end
endmodule // counter_front_panel_mode_control_tb_top
`default_nettype wire
